// ---- rtl/mpsr_pkg.sv ----
// Shared constants, types and register layout of the power-state and refresh block.
package mpsr_pkg;
	localparam int CLK_NS = 10;
	localparam int CHAN_CYCLE_NS = 10;
	localparam int FRAME_TICKS = (CHAN_CYCLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SR_PERIOD_NS = 15600;
	localparam logic [15:0] SR_CYCLES = 16'(SR_PERIOD_NS / CLK_NS);
	localparam int RAS_NS = 40;
	localparam logic [7:0] RAS_CYCLES = 8'((RAS_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [4:0] BANK_MAX = 5'h1f;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_FRAME = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam int CTRL_NSR_BIT = 8;
	localparam int CTRL_PSX_BIT = 9;
	localparam int CTRL_SLOT_BIT = 10;
	localparam int ST_FRAME_BIT = 3;
	localparam int ST_SELF_BIT = 4;
	localparam int ST_BANK_LSB = 8;
	localparam int ST_ROW_LSB = 16;

	typedef enum logic [2:0]
	{
		PS_STANDBY = 3'b000,
		PS_ATTENTION_STATE = 3'b001,
		PS_ATTENTION_STATE_RD = 3'b010,
		PS_ATTENTION_STATE_WR = 3'b011,
		PS_SLEEP = 3'b100,
		PS_PDOWN = 3'b101
	} mpsr_pstate_t;

	typedef enum logic [1:0]
	{
		WK_IDLE = 2'b00,
		WK_FELL = 2'b01,
		WK_SLOT = 2'b10
	} mpsr_wake_t;

	typedef struct packed
	{
		logic valid;
		logic bcast;
		logic [5:0] dev;
		logic is_act;
		logic attention_state;
		logic relax;
		logic sleep_req;
		logic pdn_req;
		logic refresh_activate;
		logic refresh_precharge;
		logic [4:0] bank;
		logic [9:0] row;
	} mpsr_row_t;

	typedef struct packed
	{
		logic valid;
		logic [5:0] dev;
		logic rd;
		logic wr;
		logic relax;
	} mpsr_col_t;

	typedef struct packed
	{
		logic sck;
		logic cmd;
		logic sio;
		logic [5:0] data_byte_a;
	} mpsr_wake_pins_t;

	typedef struct packed
	{
		mpsr_row_t row_s1;
		mpsr_row_t row_s2;
		logic row_v3;
		mpsr_col_t col_s1;
		mpsr_col_t col_s2;
		logic col_v3;
		mpsr_wake_pins_t wk_s1;
		mpsr_wake_pins_t wk_s2;
		logic sck_d;
		mpsr_pstate_t ps;
		logic ret_attention_state;
		logic [11:0] frame_cnt;
		logic frame_ok;
		mpsr_wake_t wk;
		logic [9:0] row_ptr;
		logic [4:0] self_bank;
		logic self_on;
		logic [15:0] sr_cnt;
		logic sr_pend;
		logic [7:0] ras_cnt;
		logic [5:0] dev_id;
		logic sleep_self_refresh_enable;
		logic exit_without_address_select;
		logic slot;
		logic [7:0] frame_fld;
		logic a_pend;
		logic a_write;
		logic [7:0] a_addr;
		logic [31:0] hrdata;
		logic rdy;
		logic act_v;
		logic [4:0] act_bank;
		logic [9:0] act_row;
		logic pre_v;
		logic [4:0] pre_bank;
	} mpsr_state_t;
endpackage

// ---- rtl/mpsr_top.sv ----
// Power-state, wake-up and refresh control with an AHB-Lite register slave.
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
module mpsr_top
	import mpsr_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [2:0] I_HSIZE,
	input wire logic [31:0] I_HWDATA,
	input wire logic I_HREADY,
	output logic [31:0] O_HRDATA,
	output logic O_HREADYOUT,
	output logic O_HRESP,
	input wire mpsr_row_t I_ROW,
	input wire mpsr_col_t I_COL,
	input wire mpsr_wake_pins_t I_WAKE,
	output logic [2:0] O_POWER_STATE,
	output logic O_COL_FRAME_EN,
	output logic O_SELF_REFRESH,
	output logic O_ACT_VALID,
	output logic [4:0] O_ACT_BANK,
	output logic [9:0] O_ACT_ROW,
	output logic O_PRE_VALID,
	output logic [4:0] O_PRE_BANK
);
	mpsr_state_t s;
	mpsr_state_t next_s;
	logic row_take;
	logic col_take;
	logic row_hit;
	logic row_mine;
	logic col_hit;
	logic sck_fall;
	logic sck_rise;
	logic wake_exit;

	function automatic logic [31:0] read_word(input mpsr_state_t st, input logic [7:0] addr);
		logic [31:0] w;
		w = 32'h0;
		case (addr)
			REG_CTRL:
			begin
				w[5:0] = st.dev_id;
				w[CTRL_NSR_BIT] = st.sleep_self_refresh_enable;
				w[CTRL_PSX_BIT] = st.exit_without_address_select;
				w[CTRL_SLOT_BIT] = st.slot;
			end
			REG_FRAME: w[7:0] = st.frame_fld;
			REG_STATUS:
			begin
				w[2:0] = st.ps;
				w[ST_FRAME_BIT] = st.frame_ok;
				w[ST_SELF_BIT] = st.self_on;
				w[ST_BANK_LSB +: 5] = st.self_bank;
				w[ST_ROW_LSB +: 10] = st.row_ptr;
			end
			default: w = 32'h0;
		endcase
		return w;
	endfunction

	function automatic logic [9:0] row_after(input logic [4:0] bank, input logic [9:0] row);
		return (bank == BANK_MAX) ? row + 10'h001 : row;
	endfunction

	assign row_take = s.row_s2.valid && !s.row_v3;
	assign col_take = s.col_s2.valid && !s.col_v3;
	assign row_hit = !s.row_s2.bcast && (s.row_s2.dev == s.dev_id);
	assign row_mine = row_hit || s.row_s2.bcast;
	assign col_hit = s.col_s2.dev == s.dev_id;
	assign sck_fall = s.sck_d && !s.wk_s2.sck;
	assign sck_rise = !s.sck_d && s.wk_s2.sck;
	assign wake_exit = s.ps[2] && sck_rise && s.wk_s2.cmd &&
		((s.wk == WK_FELL && (s.exit_without_address_select || (!s.slot && s.wk_s2.data_byte_a == s.dev_id))) ||
		(s.wk == WK_SLOT && (s.exit_without_address_select || s.wk_s2.data_byte_a == s.dev_id)));

	always_comb
	begin
		next_s = s;
		next_s.row_s1 = I_ROW;
		next_s.row_s2 = s.row_s1;
		next_s.row_v3 = s.row_s2.valid;
		next_s.col_s1 = I_COL;
		next_s.col_s2 = s.col_s1;
		next_s.col_v3 = s.col_s2.valid;
		next_s.wk_s1 = I_WAKE;
		next_s.wk_s2 = s.wk_s1;
		next_s.sck_d = s.wk_s2.sck;
		next_s.rdy = 1'b1;
		next_s.act_v = 1'b0;
		next_s.pre_v = 1'b0;

		if (I_HREADY)
		begin
			next_s.a_pend = I_HSEL && I_HTRANS[1];
			next_s.a_write = I_HWRITE;
			next_s.a_addr = I_HADDR[7:0];
			next_s.hrdata = read_word(s, I_HADDR[7:0]);
		end
		if (s.a_pend && s.a_write)
		begin
			case (s.a_addr)
				REG_CTRL:
				begin
					next_s.dev_id = I_HWDATA[5:0];
					next_s.sleep_self_refresh_enable = I_HWDATA[CTRL_NSR_BIT];
					next_s.exit_without_address_select = I_HWDATA[CTRL_PSX_BIT];
					next_s.slot = I_HWDATA[CTRL_SLOT_BIT];
				end
				REG_FRAME: next_s.frame_fld = I_HWDATA[7:0];
				default: next_s.frame_fld = s.frame_fld;
			endcase
		end

		if (!s.frame_ok && (s.ps == PS_ATTENTION_STATE || s.ps == PS_ATTENTION_STATE_RD || s.ps == PS_ATTENTION_STATE_WR))
		begin
			if (s.frame_cnt == 12'h000)
				next_s.frame_ok = 1'b1;
			else
				next_s.frame_cnt = s.frame_cnt - 12'h001;
		end

		if (!s.ps[2] && row_take)
		begin
			if (s.row_s2.refresh_activate && row_mine)
			begin
				next_s.act_v = 1'b1;
				next_s.act_bank = s.row_s2.bank;
				next_s.act_row = s.row_ptr;
				next_s.row_ptr = row_after(s.row_s2.bank, s.row_ptr);
			end
			else if (s.row_s2.refresh_precharge && row_mine)
			begin
				next_s.pre_v = 1'b1;
				next_s.pre_bank = s.row_s2.bank;
			end
			else if ((s.row_s2.sleep_req || s.row_s2.pdn_req) && row_hit)
			begin
				next_s.ret_attention_state = (s.ps != PS_STANDBY) && !s.row_s2.relax;
				next_s.ps = s.row_s2.pdn_req ? PS_PDOWN : PS_SLEEP;
				next_s.self_on = s.row_s2.pdn_req || s.sleep_self_refresh_enable;
				next_s.sr_cnt = 16'h0000;
				next_s.frame_ok = 1'b0;
				next_s.wk = WK_IDLE;
			end
			else if (s.row_s2.relax && row_mine)
			begin
				next_s.ps = PS_STANDBY;
				next_s.frame_ok = 1'b0;
			end
			else if ((s.row_s2.is_act || s.row_s2.attention_state) && row_mine)
			begin
				if (s.row_s2.is_act)
				begin
					next_s.act_v = 1'b1;
					next_s.act_bank = s.row_s2.bank;
					next_s.act_row = s.row_s2.row;
				end
				if (row_hit && s.ps == PS_STANDBY)
				begin
					next_s.ps = PS_ATTENTION_STATE;
					next_s.frame_cnt = 12'(s.frame_fld * FRAME_TICKS);
					next_s.frame_ok = 1'b0;
				end
			end
		end

		if (s.frame_ok && col_take && col_hit && !s.ps[2])
		begin
			if (s.col_s2.relax)
			begin
				next_s.ps = PS_STANDBY;
				next_s.frame_ok = 1'b0;
			end
			else if (s.col_s2.wr)
				next_s.ps = PS_ATTENTION_STATE_WR;
			else if (s.col_s2.rd)
				next_s.ps = PS_ATTENTION_STATE_RD;
		end

		if (s.ps[2])
		begin
			case (s.wk)
				WK_IDLE:
					if (sck_fall && !s.wk_s2.cmd && s.wk_s2.sio == (s.ps == PS_PDOWN))
						next_s.wk = WK_FELL;
				WK_FELL:
					if (sck_rise)
						next_s.wk = (s.wk_s2.cmd && !s.exit_without_address_select && s.slot) ? WK_SLOT : WK_IDLE;
				WK_SLOT:
					if (sck_rise)
						next_s.wk = WK_IDLE;
				default: next_s.wk = WK_IDLE;
			endcase
			if (wake_exit)
			begin
				next_s.ps = s.ret_attention_state ? PS_ATTENTION_STATE : PS_STANDBY;
				next_s.wk = WK_IDLE;
				next_s.self_on = 1'b0;
				next_s.sr_pend = 1'b0;
				next_s.frame_cnt = 12'(s.frame_fld * FRAME_TICKS);
			end
		end

		if (s.self_on && !wake_exit)
		begin
			if (s.sr_cnt == SR_CYCLES - 16'h0001)
			begin
				next_s.sr_cnt = 16'h0000;
				next_s.act_v = 1'b1;
				next_s.act_bank = s.self_bank;
				next_s.act_row = s.row_ptr;
				next_s.sr_pend = 1'b1;
				next_s.ras_cnt = RAS_CYCLES;
			end
			else
				next_s.sr_cnt = s.sr_cnt + 16'h0001;
			if (s.sr_pend)
			begin
				if (s.ras_cnt == 8'h01)
				begin
					next_s.sr_pend = 1'b0;
					next_s.pre_v = 1'b1;
					next_s.pre_bank = s.self_bank;
					next_s.self_bank = s.self_bank + 5'h01;
					next_s.row_ptr = row_after(s.self_bank, s.row_ptr);
				end
				else
					next_s.ras_cnt = s.ras_cnt - 8'h01;
			end
		end
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			// The serial clock idles high, so its synchroniser starts high and reset makes no false edge.
			s <= '0;
			s.wk_s1.sck <= 1'b1;
			s.wk_s2.sck <= 1'b1;
			s.sck_d <= 1'b1;
		end
		else
			s <= next_s;
	end

	assign O_HRDATA = s.hrdata;
	assign O_HREADYOUT = s.rdy;
	assign O_HRESP = 1'b0;
	assign O_POWER_STATE = s.ps;
	assign O_COL_FRAME_EN = s.frame_ok;
	assign O_SELF_REFRESH = s.self_on;
	assign O_ACT_VALID = s.act_v;
	assign O_ACT_BANK = s.act_bank;
	assign O_ACT_ROW = s.act_row;
	assign O_PRE_VALID = s.pre_v;
	assign O_PRE_BANK = s.pre_bank;

	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);

	sequence seq_addr_act;
		row_take && s.row_s2.is_act && row_hit && s.ps == PS_STANDBY && !s.row_s2.refresh_activate;
	endsequence
	sequence seq_slot_wake;
		s.ps[2] && s.wk == WK_FELL && sck_rise && s.wk_s2.cmd && !s.exit_without_address_select && s.slot;
	endsequence
	sequence seq_slot_match;
		s.ps[2] && s.wk == WK_SLOT && sck_rise && s.wk_s2.cmd && s.wk_s2.data_byte_a == s.dev_id;
	endsequence

	a_attention_state_entry: assert property (seq_addr_act |=> s.ps == PS_ATTENTION_STATE && s.act_v)
		else $error("Addressed activate did not enter attention.");
	a_frame_wait: assert property ((seq_addr_act and (s.frame_fld != 8'h00))
		|=> !s.frame_ok ##1 !s.frame_ok)
		else $error("Column framing enabled too early.");
	a_attention_state_write: assert property (s.frame_ok && col_take && col_hit && s.col_s2.wr && !s.col_s2.relax &&
		!s.ps[2] && !row_take |=> s.ps == PS_ATTENTION_STATE_WR)
		else $error("Write command did not select attention write.");
	a_attention_state_read: assert property (s.frame_ok && col_take && col_hit && s.col_s2.rd && !s.col_s2.wr &&
		!s.col_s2.relax && !s.ps[2] && !row_take |=> s.ps == PS_ATTENTION_STATE_RD)
		else $error("Read command did not select attention read.");
	a_col_relax: assert property (s.frame_ok && col_take && col_hit && s.col_s2.relax && !s.ps[2]
		|=> s.ps == PS_STANDBY)
		else $error("Column relax did not return to standby.");
	a_bcast_keep: assert property (row_take && s.row_s2.bcast && s.row_s2.is_act && !s.row_s2.relax &&
		!s.row_s2.refresh_activate && !s.row_s2.refresh_precharge && !s.ps[2] && !col_take |=> s.ps == $past(s.ps))
		else $error("Broadcast activate changed power state.");
	a_bcast_relax: assert property (row_take && s.row_s2.bcast && s.row_s2.relax && !s.row_s2.refresh_activate &&
		!s.row_s2.refresh_precharge && !s.ps[2] && !col_take |=> s.ps == PS_STANDBY)
		else $error("Broadcast relax did not return to standby.");
	a_sleep_return: assert property (wake_exit |=> s.ps == ($past(s.ret_attention_state) ? PS_ATTENTION_STATE : PS_STANDBY))
		else $error("Sleep exit went to the wrong state.");
	a_slot_wait: assert property (seq_slot_wake |=> s.ps[2] && s.wk == WK_SLOT)
		else $error("Late slot exited before its rising edge.");
	a_slot_exit: assert property (seq_slot_match |=> !s.ps[2])
		else $error("Late slot match did not exit.");
	a_psx_exit: assert property (s.ps[2] && s.exit_without_address_select && s.wk == WK_FELL && sck_rise && s.wk_s2.cmd
		|=> !s.ps[2])
		else $error("Address-free wake did not exit.");
	a_row_bump: assert property (!s.ps[2] && row_take && s.row_s2.refresh_activate && row_mine &&
		s.row_s2.bank == BANK_MAX |=> s.row_ptr == $past(s.row_ptr) + 10'h001 && s.act_v)
		else $error("Refresh of top bank did not bump row pointer.");
	a_self_start: assert property (!s.ps[2] && row_take && row_hit && s.row_s2.pdn_req && !s.row_s2.refresh_activate &&
		!s.row_s2.refresh_precharge |=> s.ps == PS_PDOWN && s.self_on)
		else $error("Powerdown entry did not start self-refresh.");
	a_sleep_entry: assert property (!s.ps[2] && row_take && row_hit && s.row_s2.sleep_req &&
		!s.row_s2.pdn_req && !s.row_s2.refresh_activate && !s.row_s2.refresh_precharge && !col_take
		|=> s.ps == PS_SLEEP && s.self_on == $past(s.sleep_self_refresh_enable))
		else $error("Light sleep entry did not follow the self-refresh enable.");
	a_self_pair: assert property (s.self_on && s.sr_cnt == SR_CYCLES - 16'h0001 && !wake_exit
		|=> s.act_v ##4 (s.pre_v || !s.self_on))
		else $error("Self-refresh activate was not followed by its precharge.");
endmodule

// ---- test/mpsr_ctrl_model.sv ----
// Behavioural memory controller driving the row, column and wake pins.
`timescale 1ns/1ns
module mpsr_ctrl_model
	import mpsr_pkg::*;
(
	input wire logic i_clk,
	output mpsr_row_t o_row,
	output mpsr_col_t o_col,
	output mpsr_wake_pins_t o_wake
);
	initial
	begin
		o_row = '0;
		o_col = '0;
		o_wake = 9'h100;
	end
	// A packet holds four cycles, then the released pins show inverted fields for four more.
	task automatic row(input mpsr_row_t p);
		mpsr_row_t q;
		@(posedge i_clk);
		o_row <= p;
		repeat (4) @(posedge i_clk);
		q = ~p;
		q.valid = 1'h0;
		o_row <= q;
		repeat (4) @(posedge i_clk);
	endtask
	// Callers pick refresh banks and space sleep entry and wake.
	task automatic col(input mpsr_col_t p);
		mpsr_col_t q;
		@(posedge i_clk);
		o_col <= p;
		repeat (4) @(posedge i_clk);
		q = ~p;
		q.valid = 1'h0;
		o_col <= q;
		repeat (4) @(posedge i_clk);
	endtask
	// The serial clock falls with command 0 and the sleep kind, then rises with command 1 and the id.
	// Command and id stay through a second serial cycle, for a device that checks the late slot.
	task automatic wake(input logic s, input logic [5:0] id);
		@(posedge i_clk);
		#3 o_wake = {1'h1, 1'h0, s, ~id};
		#40 o_wake.sck = 1'h0;
		#40 o_wake = {1'h1, 1'h1, ~s, id};
		#40 o_wake.sck = 1'h0;
		#40 o_wake.sck = 1'h1;
		#40 o_wake = {1'h1, 1'h0, ~s, ~id};
		#40;
	endtask
endmodule

// ---- test/mpsr_top_tb.sv ----
// Self-checking bench for the power-state, wake-up and refresh block.
`timescale 1ns/1ns
module mpsr_top_tb
	import mpsr_pkg::*;
;
	localparam logic [6:0] ACT = 7'h40, ATN = 7'h20, RELAX_CMD = 7'h10, SLP = 7'h08, DEEP_POWERDOWN_STATE = 7'h04, RFA = 7'h02, RFP = 7'h01;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic hwrite = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] q;
	wire logic [31:0] hrdata;
	wire logic hready, hresp, fen, sref, actv, prev;
	wire logic [2:0] state;
	wire logic [4:0] actb, preb;
	wire logic [9:0] actr;
	wire mpsr_row_t row;
	wire mpsr_col_t col;
	wire mpsr_wake_pins_t wk;
	int fails = 0, tests_run = 0, acts = 0, pres = 0, cyc = 0, n, m;
	always #5 clk = ~clk;
	mpsr_ctrl_model mpsr_ctrl_model_i (.i_clk(clk), .o_row(row), .o_col(col), .o_wake(wk));
	mpsr_top mpsr_top_i (.I_CLK(clk), .I_RST(rst), .I_HSEL(1'h1), .I_HADDR(haddr), .I_HTRANS(htrans),
		.I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
		.O_HREADYOUT(hready), .O_HRESP(hresp), .I_ROW(row), .I_COL(col), .I_WAKE(wk), .O_POWER_STATE(state),
		.O_COL_FRAME_EN(fen), .O_SELF_REFRESH(sref), .O_ACT_VALID(actv), .O_ACT_BANK(actb), .O_ACT_ROW(actr),
		.O_PRE_VALID(prev), .O_PRE_BANK(preb));
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		acts <= acts + int'(actv === 1'h1);
		pres <= pres + int'(prev === 1'h1);
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			fails++;
			close_out();
		end
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic st(input mpsr_pstate_t e);
		chk("state", 32'(e), 32'(state));
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'h1);
		r = hrdata;
		chk("hresp", 32'h0, 32'(hresp));
	endtask
	task automatic rs(input logic b, input logic [5:0] d, input logic [6:0] c, input logic [4:0] k, input logic [9:0] r);
		mpsr_ctrl_model_i.row({1'h1, b, d, c, k, r});
	endtask
	task automatic cs(input logic [5:0] d, input logic [2:0] c);
		mpsr_ctrl_model_i.col({1'h1, d, c});
	endtask
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		repeat (3) @(posedge clk);
		bus(1'h0, REG_STATUS, 32'h0, q);
		chk("status", 32'h0, q);
		bus(1'h1, REG_CTRL, 32'h105, q);
		bus(1'h1, REG_FRAME, 32'h8, q);
		bus(1'h1, REG_STATUS, 32'hffffffff, q);
		bus(1'h0, REG_CTRL, 32'h0, q);
		chk("ctrl", 32'h105, q);
		bus(1'h0, 8'h40, 32'h0, q);
		chk("unmapped", 32'h0, q);
		bus(1'h0, REG_STATUS, 32'h0, q);
		chk("status", 32'h0, q);
		$display("regs done");
		rs(1'h1, 6'h5, ACT, 5'h3, 10'h7);
		st(PS_STANDBY);
		rs(1'h0, 6'h9, ACT, 5'h3, 10'h7);
		st(PS_STANDBY);
		n = acts;
		rs(1'h0, 6'h5, ACT, 5'h3, 10'h7);
		st(PS_ATTENTION_STATE);
		chk("frame", 32'h0, 32'(fen));
		chk("act count", 32'h1, 32'(acts - n));
		chk("act", 32'hc07, 32'({actb, actr}));
		repeat (8) @(posedge clk);
		chk("frame", 32'h1, 32'(fen));
		$display("attention done");
		cs(6'h5, 3'h2);
		st(PS_ATTENTION_STATE_WR);
		cs(6'h5, 3'h4);
		st(PS_ATTENTION_STATE_RD);
		cs(6'h9, 3'h1);
		st(PS_ATTENTION_STATE_RD);
		cs(6'h5, 3'h1);
		st(PS_STANDBY);
		rs(1'h0, 6'h5, ATN, 5'h0, 10'h0);
		st(PS_ATTENTION_STATE);
		rs(1'h1, 6'h0, RELAX_CMD, 5'h0, 10'h0);
		st(PS_STANDBY);
		$display("column done");
		rs(1'h0, 6'h5, ATN, 5'h0, 10'h0);
		rs(1'h0, 6'h5, SLP, 5'h0, 10'h0);
		st(PS_SLEEP);
		chk("self", 32'h1, 32'(sref));
		mpsr_ctrl_model_i.wake(1'h0, 6'h9);
		st(PS_SLEEP);
		mpsr_ctrl_model_i.wake(1'h1, 6'h5);
		st(PS_SLEEP);
		mpsr_ctrl_model_i.wake(1'h0, 6'h5);
		st(PS_ATTENTION_STATE);
		bus(1'h1, REG_CTRL, 32'h505, q);
		rs(1'h0, 6'h5, SLP, 5'h0, 10'h0);
		st(PS_SLEEP);
		mpsr_ctrl_model_i.wake(1'h0, 6'h9);
		st(PS_SLEEP);
		mpsr_ctrl_model_i.wake(1'h0, 6'h5);
		st(PS_ATTENTION_STATE);
		$display("sleep done");
		bus(1'h1, REG_CTRL, 32'h305, q);
		rs(1'h0, 6'h5, DEEP_POWERDOWN_STATE | RELAX_CMD, 5'h0, 10'h0);
		st(PS_PDOWN);
		chk("self", 32'h1, 32'(sref));
		n = acts;
		m = pres;
		repeat (1600) @(posedge clk);
		chk("self act", 32'h1, 32'(acts - n));
		chk("self pre", 32'h1, 32'(pres - m));
		mpsr_ctrl_model_i.wake(1'h1, 6'h2a);
		st(PS_STANDBY);
		chk("self", 32'h0, 32'(sref));
		$display("powerdown done");
		n = acts;
		rs(1'h1, 6'h0, RFA | ATN, 5'h1f, 10'h3ff);
		st(PS_STANDBY);
		chk("refresh_activate count", 32'h1, 32'(acts - n));
		chk("refresh_activate", 32'h7c00, 32'({actb, actr}));
		bus(1'h0, REG_STATUS, 32'h0, q);
		chk("row pointer", 32'h1, 32'(q[25:16]));
		rs(1'h1, 6'h0, RFA, 5'hc, 10'h3ff);
		chk("refresh_activate", 32'h3001, 32'({actb, actr}));
		m = pres;
		rs(1'h1, 6'h0, RFP, 5'hc, 10'h0);
		chk("refresh_precharge count", 32'h1, 32'(pres - m));
		chk("refresh_precharge", 32'hc, 32'(preb));
		$display("refresh done");
		close_out();
	end
endmodule
